// ===== hdl/ssio_ports.sv
// Segment-shared I/O ports 8, 9, 11, 12, 14 and 15
// Overview of operation
// R1: One select bit per group picks port use or LCD segment output.
// R2: Port 8 is four bits, each bit input or output by direction bit.
// R3: Port 8 pull-up per pin, enabled by its pull-up register bit.
// R4: Port 9 is four bits with per-bit direction control.
// R5: Port 9 pull-up per pin, enabled by its pull-up register bit.
// R6: Segment mode: port 8 carries segments 4-7, port 9 segments 8-11.
// R7: Port 11 is four bits with output latch and per-bit direction.
// R8: Port 11 pull-ups enabled per bit, active only in input mode.
// R9: Reset puts every port pin into input mode.
// R10: Port 11 carries segments 16-19; bit 2 serial transmit, bit 3 receive.
// R11: Port 12 has one bidirectional bit, four input bits; pull-up bit 0 only.
// R12: Ports 14, 15 share segments 24-31 with key-scan outputs 0-7.
// R13: Segment use disables the port driver and pull-up of that pin.
module ssio_ports (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cfg_we,
  input wire logic [ssio_pkg::AW-1:0] cfg_addr,
  input wire logic [ssio_pkg::DW-1:0] cfg_wdata,
  output logic [ssio_pkg::DW-1:0] cfg_rdata,
  input wire logic [3:0] lcd_seg_out_4_7,
  input wire logic [3:0] lcd_seg_out_8_11,
  input wire logic [3:0] lcd_seg_out_16_19,
  input wire logic [7:0] lcd_seg_out_24_31,
  input wire logic [7:0] key_scan_out_0_7,
  input wire logic key_scan_active,
  input wire logic serial_tx_en,
  input wire logic serial_tx_line,
  output logic serial_rx_line,
  input wire logic [3:0] port8_pins_in,
  output logic [3:0] port8_pins_out,
  output logic [3:0] port8_pins_oe,
  output logic [3:0] port8_pins_pu,
  input wire logic [3:0] port9_pins_in,
  output logic [3:0] port9_pins_out,
  output logic [3:0] port9_pins_oe,
  output logic [3:0] port9_pins_pu,
  input wire logic [3:0] port11_pins_in,
  output logic [3:0] port11_pins_out,
  output logic [3:0] port11_pins_oe,
  output logic [3:0] port11_pins_pu,
  input wire logic port12_bidir_bit_in,
  output logic port12_bidir_bit_out,
  output logic port12_bidir_bit_oe,
  output logic port12_bidir_bit_pu,
  input wire logic [3:0] port12_in_only,
  input wire logic [3:0] port14_pins_in,
  output logic [3:0] port14_pins_out,
  output logic [3:0] port14_pins_oe,
  output logic [3:0] port14_pins_pu,
  input wire logic [3:0] port15_pins_in,
  output logic [3:0] port15_pins_out,
  output logic [3:0] port15_pins_oe,
  output logic [3:0] port15_pins_pu
);
  localparam int NP = ssio_pkg::NPORT;
  localparam int W = ssio_pkg::PW;

  logic [ssio_pkg::FSW-1:0] global_pin_function_select;
  logic [ssio_pkg::FSW-1:0] fsel_next;
  logic [W-1:0] dir_reg [0:NP-1];
  logic [W-1:0] dir_next [0:NP-1];
  logic [W-1:0] pu_reg [0:NP-1];
  logic [W-1:0] pu_next [0:NP-1];
  logic [W-1:0] latch_reg [0:NP-1];
  logic [W-1:0] latch_next [0:NP-1];
  logic [ssio_pkg::DW-1:0] rdata_reg;
  logic [ssio_pkg::DW-1:0] rdata_next;
  logic [NP-1:0] seg_sel_a;
  logic [W-1:0] seg_a [0:NP-1];
  logic [W-1:0] alt_en_a [0:NP-1];
  logic [W-1:0] alt_data_a [0:NP-1];
  logic [W-1:0] pin_in_a [0:NP-1];
  logic [W-1:0] out_a [0:NP-1];
  logic [W-1:0] oe_a [0:NP-1];
  logic [W-1:0] pu_a [0:NP-1];
  logic [W-1:0] sync_a [0:NP-1];
  logic [W-1:0] rd_a [0:NP-1];

  // True when addr selects register kind of slot idx
  function automatic logic ssio_reg_hit(
    input logic [ssio_pkg::AW-1:0] addr,
    input int idx,
    input logic [1:0] kind
  );
    ssio_reg_hit = addr == ssio_pkg::AW'(int'(ssio_pkg::ADDR_BASE) +
      ssio_pkg::REGS_PER_PORT * idx + int'(kind));
  endfunction : ssio_reg_hit

  // Merge a write into the writable bits of a slot
  function automatic logic [W-1:0] ssio_merge(
    input logic [W-1:0] old_val,
    input logic [W-1:0] new_val,
    input logic [W-1:0] mask
  );
    ssio_merge = (old_val & ~mask) | (new_val & mask);
  endfunction : ssio_merge

  always_comb begin
    fsel_next = global_pin_function_select;
    rdata_next = ssio_pkg::RDATA_RST;
    if (cfg_addr == ssio_pkg::ADDR_FSEL) begin
      rdata_next = {3'h0, global_pin_function_select};
      if (cfg_we) begin
        fsel_next = cfg_wdata[ssio_pkg::FSW-1:0]; // [R1]
      end
    end
    for (int i = 0; i < NP; i++) begin
      dir_next[i] = dir_reg[i];
      pu_next[i] = pu_reg[i];
      latch_next[i] = latch_reg[i];
      if (ssio_reg_hit(cfg_addr, i, ssio_pkg::KIND_DIR)) begin
        rdata_next = {4'h0, dir_reg[i]};
        if (cfg_we) begin
          // [R2] [R4] [R7]
          dir_next[i] = ssio_merge(dir_reg[i], cfg_wdata[W-1:0],
            ssio_pkg::WR_MASK[i]);
        end
      end
      if (ssio_reg_hit(cfg_addr, i, ssio_pkg::KIND_PU)) begin
        rdata_next = {4'h0, pu_reg[i]};
        if (cfg_we) begin
          // Port 12 mask leaves only the bidirectional bit writable [R11]
          pu_next[i] = ssio_merge(pu_reg[i], cfg_wdata[W-1:0],
            ssio_pkg::WR_MASK[i]);
        end
      end
      if (ssio_reg_hit(cfg_addr, i, ssio_pkg::KIND_DATA)) begin
        rdata_next = {4'h0, rd_a[i]};
        if (cfg_we) begin
          latch_next[i] = ssio_merge(latch_reg[i], cfg_wdata[W-1:0],
            ssio_pkg::WR_MASK[i]);
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_pin_function_select <= ssio_pkg::FSEL_RST;
      rdata_reg <= ssio_pkg::RDATA_RST;
      for (int i = 0; i < NP; i++) begin
        dir_reg[i] <= ssio_pkg::DIR_RST; // [R9]
        pu_reg[i] <= ssio_pkg::PU_RST;
        latch_reg[i] <= ssio_pkg::LATCH_RST;
      end
    end else begin
      global_pin_function_select <= fsel_next;
      rdata_reg <= rdata_next;
      for (int i = 0; i < NP; i++) begin
        dir_reg[i] <= dir_next[i];
        pu_reg[i] <= pu_next[i];
        latch_reg[i] <= latch_next[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NP; i++) begin
      seg_sel_a[i] = ssio_pkg::FSEL_HAS[i] &
        global_pin_function_select[ssio_pkg::FSEL_POS[i]]; // [R1]
      alt_en_a[i] = '0;
      alt_data_a[i] = '0;
    end
    seg_a[ssio_pkg::IDX_P8] = lcd_seg_out_4_7; // [R6]
    seg_a[ssio_pkg::IDX_P9] = lcd_seg_out_8_11; // [R6]
    seg_a[ssio_pkg::IDX_PORT11] = lcd_seg_out_16_19; // [R10]
    seg_a[ssio_pkg::IDX_P12] = '0;
    // Key-scan drive replaces the segment level while scanning [R12]
    seg_a[ssio_pkg::IDX_P14] = key_scan_active ? key_scan_out_0_7[3:0] :
      lcd_seg_out_24_31[3:0];
    seg_a[ssio_pkg::IDX_P15] = key_scan_active ? key_scan_out_0_7[7:4] :
      lcd_seg_out_24_31[7:4];
    seg_a[ssio_pkg::IDX_P12IN] = '0;
    // Serial transmit overrides the latch on its pin in port mode [R10]
    alt_en_a[ssio_pkg::IDX_PORT11][ssio_pkg::TX_BIT] = serial_tx_en;
    alt_data_a[ssio_pkg::IDX_PORT11][ssio_pkg::TX_BIT] = serial_tx_line;
    pin_in_a[ssio_pkg::IDX_P8] = port8_pins_in;
    pin_in_a[ssio_pkg::IDX_P9] = port9_pins_in;
    pin_in_a[ssio_pkg::IDX_PORT11] = port11_pins_in;
    pin_in_a[ssio_pkg::IDX_P12] = {3'h0, port12_bidir_bit_in};
    pin_in_a[ssio_pkg::IDX_P14] = port14_pins_in;
    pin_in_a[ssio_pkg::IDX_P15] = port15_pins_in;
    pin_in_a[ssio_pkg::IDX_P12IN] = port12_in_only; // [R11]
  end

  for (genvar g = 0; g < NP; g++) begin : g_slice
    ssio_port_slice #(.WIDTH(W)) u_slice (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .seg_sel(seg_sel_a[g]),
      .dir_in(dir_reg[g]),
      .pu_en(pu_reg[g]),
      .latch(latch_reg[g]),
      .seg_data(seg_a[g]),
      .alt_en(alt_en_a[g]),
      .alt_data(alt_data_a[g]),
      .pin_in(pin_in_a[g]),
      .pin_out_reg(out_a[g]),
      .pin_oe_reg(oe_a[g]),
      .pin_pu_reg(pu_a[g]),
      .pin_sync_reg(sync_a[g]),
      .rd_data_reg(rd_a[g])
    );
  end

  assign cfg_rdata = rdata_reg;
  assign serial_rx_line =
    sync_a[ssio_pkg::IDX_PORT11][ssio_pkg::RX_BIT]; // [R10]
  assign port8_pins_out = out_a[ssio_pkg::IDX_P8];
  assign port8_pins_oe = oe_a[ssio_pkg::IDX_P8];
  assign port8_pins_pu = pu_a[ssio_pkg::IDX_P8];
  assign port9_pins_out = out_a[ssio_pkg::IDX_P9];
  assign port9_pins_oe = oe_a[ssio_pkg::IDX_P9];
  assign port9_pins_pu = pu_a[ssio_pkg::IDX_P9];
  assign port11_pins_out = out_a[ssio_pkg::IDX_PORT11];
  assign port11_pins_oe = oe_a[ssio_pkg::IDX_PORT11];
  assign port11_pins_pu = pu_a[ssio_pkg::IDX_PORT11];
  assign port12_bidir_bit_out = out_a[ssio_pkg::IDX_P12][0];
  assign port12_bidir_bit_oe = oe_a[ssio_pkg::IDX_P12][0];
  assign port12_bidir_bit_pu = pu_a[ssio_pkg::IDX_P12][0];
  assign port14_pins_out = out_a[ssio_pkg::IDX_P14];
  assign port14_pins_oe = oe_a[ssio_pkg::IDX_P14];
  assign port14_pins_pu = pu_a[ssio_pkg::IDX_P14];
  assign port15_pins_out = out_a[ssio_pkg::IDX_P15];
  assign port15_pins_oe = oe_a[ssio_pkg::IDX_P15];
  assign port15_pins_pu = pu_a[ssio_pkg::IDX_P15];

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_fsel_write;
    cfg_we && cfg_addr == ssio_pkg::ADDR_FSEL |=>
      global_pin_function_select == $past(cfg_wdata[ssio_pkg::FSW-1:0]);
  endproperty
  a_fsel_write: assert property (p_fsel_write) // [R1]
    else $error("function select write not stored");

  property p_reset_inputs;
    $rose(rst_n) |-> port8_pins_oe == 4'h0 && port11_pins_oe == 4'h0 &&
      port15_pins_oe == 4'h0 && !port12_bidir_bit_oe;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) // [R9]
    else $error("pins not in input mode after reset");

  sequence s_tx_path;
    !global_pin_function_select[ssio_pkg::FSEL_POS[ssio_pkg::IDX_PORT11]] &&
      serial_tx_en;
  endsequence
  // Pad register takes the transmit level of the cycle the path was open
  property p_tx_drive;
    s_tx_path |=>
      port11_pins_out[ssio_pkg::TX_BIT] == $past(serial_tx_line);
  endproperty
  a_tx_drive: assert property (p_tx_drive) // [R10]
    else $error("transmit data not on port 11 bit 2");

  property p_keyscan;
    global_pin_function_select[ssio_pkg::FSEL_POS[ssio_pkg::IDX_P14]] &&
      key_scan_active |=>
      port14_pins_out == $past(key_scan_out_0_7[3:0]) &&
      port14_pins_oe == 4'hF;
  endproperty
  a_keyscan: assert property (p_keyscan) // [R12]
    else $error("key-scan level not on port 14");

  property p_p12_pu_bit0;
    pu_reg[ssio_pkg::IDX_P12][3:1] == 3'h0 &&
      pu_reg[ssio_pkg::IDX_P12IN] == 4'h0;
  endproperty
  a_p12_pu_bit0: assert property (p_p12_pu_bit0) // [R11]
    else $error("pull-up enabled on a port 12 input-only bit");
endmodule : ssio_ports

// ===== hdl/ssio_pkg.sv
// Shared constants for the segment-shared I/O port block
package ssio_pkg;
  localparam int NPORT = 7;
  localparam int PW = 4;
  localparam int DW = 8;
  localparam int AW = 5;
  localparam int FSW = 5;
  // Port slots: 8, 9, 11, 12 bidir bit, 14, 15, 12 input-only bits
  localparam int IDX_P8 = 0;
  localparam int IDX_P9 = 1;
  localparam int IDX_PORT11 = 2;
  localparam int IDX_P12 = 3;
  localparam int IDX_P14 = 4;
  localparam int IDX_P15 = 5;
  localparam int IDX_P12IN = 6;
  // Register map: function select, then direction/pull-up/data per slot
  localparam logic [AW-1:0] ADDR_FSEL = 5'h00;
  localparam logic [AW-1:0] ADDR_BASE = 5'h01;
  localparam int REGS_PER_PORT = 3;
  localparam logic [1:0] KIND_DIR = 2'h0;
  localparam logic [1:0] KIND_PU = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;
  // Reset values: direction 1 means input
  localparam logic [PW-1:0] DIR_RST = 4'hF;
  localparam logic [PW-1:0] PU_RST = 4'h0;
  localparam logic [PW-1:0] LATCH_RST = 4'h0;
  localparam logic [FSW-1:0] FSEL_RST = 5'h00;
  localparam logic [DW-1:0] RDATA_RST = 8'h00;
  // Writable bits per slot
  localparam logic [PW-1:0] WR_MASK [0:NPORT-1] =
    '{4'hF, 4'hF, 4'hF, 4'h1, 4'hF, 4'hF, 4'h0};
  // Function select bit owned by each slot; FSEL_HAS leaves both port 12 slots without one
  localparam int FSEL_POS [0:NPORT-1] = '{0, 1, 2, 0, 3, 4, 0};
  localparam logic [NPORT-1:0] FSEL_HAS = 7'h37;
  localparam int TX_BIT = 2;
  localparam int RX_BIT = 3;
endpackage : ssio_pkg

// ===== hdl/ssio_port_slice.sv
// One 4-bit pin group: pin synchroniser, pad drive and read-back
module ssio_port_slice #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic seg_sel,
  input wire logic [WIDTH-1:0] dir_in,
  input wire logic [WIDTH-1:0] pu_en,
  input wire logic [WIDTH-1:0] latch,
  input wire logic [WIDTH-1:0] seg_data,
  input wire logic [WIDTH-1:0] alt_en,
  input wire logic [WIDTH-1:0] alt_data,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out_reg,
  output logic [WIDTH-1:0] pin_oe_reg,
  output logic [WIDTH-1:0] pin_pu_reg,
  output logic [WIDTH-1:0] pin_sync_reg,
  output logic [WIDTH-1:0] rd_data_reg
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] pin_out_next;
  logic [WIDTH-1:0] pin_oe_next;
  logic [WIDTH-1:0] pin_pu_next;
  logic [WIDTH-1:0] pin_sync_next;
  logic [WIDTH-1:0] rd_data_next;

  always_comb begin
    // A pin change counts once stages two and three agree
    pin_sync_next = (s2_reg & s3_reg) | (pin_sync_reg & (s2_reg ^ s3_reg));
    if (seg_sel) begin
      // Segment driver owns the pad, port driver and pull-up off
      pin_out_next = seg_data; // [R6] [R13]
      pin_oe_next = {WIDTH{1'b1}}; // [R1] [R13]
      pin_pu_next = '0; // [R13]
    end else begin
      pin_out_next = (alt_en & alt_data) | (~alt_en & latch);
      pin_oe_next = ~dir_in; // [R2] [R4] [R7]
      pin_pu_next = pu_en & dir_in; // [R3] [R5] [R8]
    end
    rd_data_next = (dir_in & pin_sync_reg) | (~dir_in & latch);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      pin_sync_reg <= '0;
      pin_out_reg <= '0;
      pin_oe_reg <= '0; // [R9]
      pin_pu_reg <= '0;
      rd_data_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_sync_reg <= pin_sync_next;
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
      pin_pu_reg <= pin_pu_next;
      rd_data_reg <= rd_data_next;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_seg_mode;
    seg_sel;
  endsequence
  sequence s_port_mode;
    !seg_sel;
  endsequence
  sequence s_pin_held;
    $stable(pin_in) [*4];
  endsequence

  property p_seg_owns;
    s_seg_mode |=> pin_oe_reg == {WIDTH{1'b1}} && pin_pu_reg == '0 &&
      pin_out_reg == $past(seg_data);
  endproperty
  a_seg_owns: assert property (p_seg_owns) // [R6] [R13]
    else $error("segment mode does not own the pads");

  property p_dir_drive;
    s_port_mode |=> pin_oe_reg == ~$past(dir_in);
  endproperty
  a_dir_drive: assert property (p_dir_drive) // [R2] [R4] [R7]
    else $error("driver enable does not follow direction");

  property p_pu_input;
    s_port_mode |=> pin_pu_reg == ($past(pu_en) & $past(dir_in));
  endproperty
  a_pu_input: assert property (p_pu_input) // [R3] [R5] [R8]
    else $error("pull-up active outside input mode");

  property p_sync_settle;
    s_pin_held |=> pin_sync_reg == $past(pin_in);
  endproperty
  a_sync_settle: assert property (p_sync_settle) // [R2]
    else $error("steady pin level not seen after synchroniser");
endmodule : ssio_port_slice

// ===== testbench/ssio_pin_model.sv
// Pad model: resolves every pin level from driver, pull-up and far side
module ssio_pin_model #(
  parameter int W = 21
) (
  input wire logic core_clk,
  input wire logic [W-1:0] drv_out,
  input wire logic [W-1:0] drv_oe,
  input wire logic [W-1:0] drv_pu,
  input wire logic [W-1:0] ext_drv,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] float_reg = '0;
  // A pin nobody drives or pulls wanders, so no check may lean on it
  always @(posedge core_clk) float_reg <= ~float_reg;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (drv_oe[i]) pin_lvl[i] = drv_out[i];
      else if (ext_drv[i]) pin_lvl[i] = ext_val[i];
      else if (drv_pu[i]) pin_lvl[i] = 1'b1;
      else pin_lvl[i] = float_reg[i];
    end
  end
endmodule : ssio_pin_model

// ===== testbench/ssio_ports_tb.sv
// Self-checking bench for the segment-shared I/O ports
module ssio_ports_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_we = 1'b0;
  logic [4:0] cfg_addr = 5'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata;
  logic [3:0] s47 = 4'h5, s811 = 4'hA, s1619 = 4'h3, p12_in = 4'hA;
  logic [7:0] s2431 = 8'hC6, ks = 8'h39;
  logic ks_act = 1'b0, tx_en = 1'b0, tx_line = 1'b0, rx;
  logic [20:0] d_out, d_oe, d_pu, lvl;
  logic [20:0] ext_drv = 21'h110888, ext_val = 21'h000000;
  logic [3:0] o8, e8, u8, o9, e9, u9, o11, e11, u11;
  logic [3:0] o14, e14, u14, o15, e15, u15;
  logic o12, e12, u12;
  int mismatches = 0;
  int compares = 0;
  int sl[5] = '{0, 1, 2, 4, 5};

  initial begin
    forever #4 core_clk = ~core_clk;
  end
  assign d_out = {o15, o14, o12, o11, o9, o8};
  assign d_oe = {e15, e14, e12, e11, e9, e8};
  assign d_pu = {u15, u14, u12, u11, u9, u8};

  ssio_ports dut (.core_clk(core_clk), .rst_n(rst_n), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .lcd_seg_out_4_7(s47), .lcd_seg_out_8_11(s811),
    .lcd_seg_out_16_19(s1619), .lcd_seg_out_24_31(s2431),
    .key_scan_out_0_7(ks), .key_scan_active(ks_act),
    .serial_tx_en(tx_en), .serial_tx_line(tx_line), .serial_rx_line(rx),
    .port8_pins_in(lvl[3:0]), .port8_pins_out(o8), .port8_pins_oe(e8),
    .port8_pins_pu(u8), .port9_pins_in(lvl[7:4]), .port9_pins_out(o9),
    .port9_pins_oe(e9), .port9_pins_pu(u9), .port11_pins_in(lvl[11:8]),
    .port11_pins_out(o11), .port11_pins_oe(e11), .port11_pins_pu(u11),
    .port12_bidir_bit_in(lvl[12]), .port12_bidir_bit_out(o12),
    .port12_bidir_bit_oe(e12), .port12_bidir_bit_pu(u12),
    .port12_in_only(p12_in), .port14_pins_in(lvl[16:13]),
    .port14_pins_out(o14), .port14_pins_oe(e14), .port14_pins_pu(u14),
    .port15_pins_in(lvl[20:17]), .port15_pins_out(o15),
    .port15_pins_oe(e15), .port15_pins_pu(u15));
  ssio_pin_model #(.W(21)) pads_i (.core_clk(core_clk), .drv_out(d_out),
    .drv_oe(d_oe), .drv_pu(d_pu), .ext_drv(ext_drv), .ext_val(ext_val),
    .pin_lvl(lvl));

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    cfg_we = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    tick(1);
    cfg_we = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    cfg_addr = a;
    tick(1);
    d = cfg_rdata;
  endtask : rd
  // Out, enable and pull-up of one 4-bit slot
  function automatic logic [11:0] pads(input int k);
    case (k)
      0: return {o8, e8, u8};
      1: return {o9, e9, u9};
      2: return {o11, e11, u11};
      4: return {o14, e14, u14};
      default: return {o15, e15, u15};
    endcase
  endfunction : pads

  task automatic t_reset();
    logic [7:0] d;
    foreach (sl[i]) begin
      chk(pads(sl[i]), 12'h000);
      rd(5'(1 + 3 * sl[i]), d);
      chk({4'h0, d}, 12'h00F);
    end
    chk({9'h000, o12, e12, u12}, 12'h000);
    rd(5'h00, d);
    chk({4'h0, d}, 12'h000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_port();
    logic [7:0] d;
    logic [11:0] p;
    foreach (sl[i]) begin
      wr(5'(1 + 3 * sl[i]), 8'h0E);
      wr(5'(2 + 3 * sl[i]), 8'h07);
      wr(5'(3 + 3 * sl[i]), 8'h05);
      tick(8);
      p = pads(sl[i]);
      chk({p[11:8] & 4'h1, p[7:0]}, 12'h116);
      rd(5'(3 + 3 * sl[i]), d);
      chk({4'h0, d}, 12'h007);
      rd(5'(2 + 3 * sl[i]), d);
      chk({4'h0, d}, 12'h007);
    end
    $display("test port mode done");
  endtask : t_port

  task automatic t_seg();
    logic [3:0] e[6];
    e = '{s47, s811, s1619, 4'h0, s2431[3:0], s2431[7:4]};
    tx_en = 1'b1;
    wr(5'h00, 8'h1F);
    foreach (sl[i]) chk(pads(sl[i]), {e[sl[i]], 8'hF0});
    ks_act = 1'b1;
    tick(2);
    chk({o14, e14, u14}, {ks[3:0], 8'hF0});
    chk({o15, e15, u15}, {ks[7:4], 8'hF0});
    wr(5'h00, 8'h00);
    tick(1);
    chk(pads(0), 12'h516);
    ks_act = 1'b0;
    tx_en = 1'b0;
    $display("test segment mode done");
  endtask : t_seg

  task automatic t_serial();
    wr(5'h07, 8'h0B);
    wr(5'h09, 8'h00);
    tx_en = 1'b1;
    tx_line = 1'b1;
    tick(2);
    chk({10'h000, o11[2], e11[2]}, 12'h003);
    tx_line = 1'b0;
    tick(2);
    chk({10'h000, o11[2], e11[2]}, 12'h001);
    ext_val[11] = 1'b1;
    tick(6);
    chk({11'h000, rx}, 12'h001);
    ext_val[11] = 1'b0;
    tick(6);
    chk({11'h000, rx}, 12'h000);
    tx_en = 1'b0;
    $display("test serial done");
  endtask : t_serial

  task automatic t_p12();
    logic [7:0] d;
    wr(5'h0A, 8'h00);
    rd(5'h0A, d);
    chk({4'h0, d}, 12'h00E);
    wr(5'h0B, 8'h0F);
    rd(5'h0B, d);
    chk({4'h0, d}, 12'h001);
    chk({9'h000, e12, u12, 1'b0}, 12'h004);
    wr(5'h0C, 8'h01);
    tick(1);
    chk({9'h000, o12, e12, u12}, 12'h006);
    wr(5'h0A, 8'h0F);
    tick(1);
    chk({9'h000, e12, u12, 1'b0}, 12'h002);
    wr(5'h15, 8'h05);
    tick(6);
    rd(5'h15, d);
    chk({4'h0, d}, 12'h00A);
    wr(5'h1F, 8'hFF);
    rd(5'h1F, d);
    chk({4'h0, d}, 12'h000);
    $display("test port 12 done");
  endtask : t_p12

  // Reset again with outputs configured; every pin must fall back to input
  task automatic t_midreset();
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    t_reset();
    $display("test mid-run reset done");
  endtask : t_midreset

  task automatic wrap_up();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    tick(5);
    rst_n = 1'b1;
    t_reset();
    t_port();
    t_seg();
    t_serial();
    t_p12();
    t_midreset();
    wrap_up();
  end
  initial begin
    #20000;
    mismatches++;
    wrap_up();
  end
endmodule : ssio_ports_tb
